// File: verilog/ush_hist.v
// upstream sample histogram engine with apb registers and result record stream
// Overview of operation
// - platform identifier emitted null-terminated
// - remote node id, else all zeros
// - remote upstream port, else zero
// - symmetry flag carried in header
// - even mode: bins 0-255 all valid
// - even mode: bin equals sample plus half
// - odd mode: bin 0 unused, reads zero
// - odd mode: bin 128 centred at zero
// - dwell length field precedes dwell values
// - dwell values are 32-bit words
// - equal dwell reported once, length one
// - hit length field precedes hit values
// - hits 32-bit, 255 entries when odd
// - destination zero local, else existing profile
// - dwell maximum ends capture, reports counts
// - timeout with no tally update pending clears enable, stores, sample ready
// - enable only when not busy; clear ends
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "ush_defines.vh"
module ush_hist #(
   parameter SEC_TICKS = `USH_SEC_TICKS // cycles per timeout second
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   input wire smp_valid, // sample stream, same clock
   input wire [7:0] smp_data,
   output wire smp_ready,
   input wire [15:0] profile_map, // bit n set: transfer profile n exists
   output wire [5:0] id_index, // platform id word being fetched
   input wire [31:0] id_word, // platform id characters, first in bits 31:24
   output reg rec_valid,
   output reg [31:0] rec_data,
   output reg rec_last,
   input wire rec_ready,
   output reg [3:0] rec_dest, // result_destination_selector of this record
   output reg rec_local, // record is kept locally
   output wire irq
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam S_IDLE = 3'h0;
   localparam S_CLEAR = 3'h1;
   localparam S_RUN = 3'h2;
   localparam S_FETCH = 3'h3;
   localparam S_LOAD = 3'h4;
   localparam S_WAIT = 3'h5;

   // ----------------------------------------
   // functions
   // ----------------------------------------
   // bin index of a two's-complement sample
   function [7:0] bin_of;
      input [7:0] s;
      begin
         bin_of = {~s[7], s[6:0]};
      end
   endfunction
   // address is a register of this block
   function is_mapped;
      input [7:0] a;
      begin
         is_mapped = (a[1:0] == 2'h0) && (a <= `USH_INT_MASK);
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [2:0] state_ff; // engine state
   reg en_ff; // enable, reads back collecting
   reg odd_ff; // symmetry flag, true is odd
   reg remote_ff; // channel sits on remote_phy_node
   reg [15:0] timeout_ff; // seconds, zero is none
   reg [3:0] dest_ff; // result_destination_selector
   reg [31:0] rnode_lo_ff; // remote node id low bits
   reg [15:0] rnode_hi_ff; // remote node id high bits
   reg [7:0] rport_ff; // remote upstream port
   reg [1:0] meas_ff; // measurement_state
   reg [31:0] dwell_ff; // bin_time_tally, same for every bin
   reg [2:0] ist_ff; // sticky interrupt status
   reg [2:0] imask_ff; // interrupt mask
   reg [31:0] tick_ff; // cycles within current second
   reg [15:0] sec_ff; // seconds elapsed
   reg upd_ff; // tally update pending
   reg [7:0] bin_ff; // bin of pending update
   reg skip_ff; // pending sample is ignored
   reg [8:0] idx_ff; // clear address or record word index
   reg err_ff; // current apb access refused
   wire [31:0] mem_rd; // tally read data
   reg [7:0] mem_ra; // tally read address
   reg mem_we; // tally write
   reg [7:0] mem_wa;
   reg [31:0] mem_wd;
   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   wire setup = psel & ~penable; // first cycle of a transfer
   wire wr_go = psel & penable & pwrite & ~err_ff; // write takes effect
   wire busy = (meas_ff == `USH_MS_BUSY);
   wire dwell_max = (dwell_ff == 32'hffffffff);
   wire tmo_hit = (timeout_ff != 16'h0000) && (tick_ff == SEC_TICKS - 1) && (sec_ff + 16'h0001 == timeout_ff);
   wire stop = (state_ff == S_RUN) & ~upd_ff & (~en_ff | tmo_hit | dwell_max);
   wire [8:0] last_w = odd_ff ? `USH_W_LAST_ODD : `USH_W_LAST_EVEN;
   wire [8:0] hit_off = idx_ff - `USH_W_HIT0;
   wire [7:0] hit_bin = odd_ff ? hit_off[7:0] + 8'h01 : hit_off[7:0];
   wire take = smp_valid & smp_ready;
   assign pready = 1'b1; // zero-wait slave
   assign smp_ready = (state_ff == S_RUN) & en_ff & ~upd_ff & ~dwell_max;
   assign id_index = idx_ff[5:0];
   assign irq = |(ist_ff & imask_ff);
   // refusal check in the setup cycle
   reg bad; // access to refuse
   always @* begin
      bad = ~is_mapped(paddr);
      if (pwrite && paddr == `USH_CTRL && pwdata[`USH_CTRL_EN] && busy) begin
         bad = 1'b1;
      end else if (pwrite && paddr == `USH_DEST && pwdata[3:0] != 4'h0 && !profile_map[pwdata[3:0]]) begin
         bad = 1'b1;
      end
   end
   // read data mux
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      if (paddr == `USH_CTRL) begin
         rd_mux = {29'h0, remote_ff, odd_ff, en_ff};
      end else if (paddr == `USH_TIMEOUT) begin
         rd_mux = {16'h0, timeout_ff};
      end else if (paddr == `USH_DEST) begin
         rd_mux = {28'h0, dest_ff};
      end else if (paddr == `USH_RNODE_LO) begin
         rd_mux = rnode_lo_ff;
      end else if (paddr == `USH_RNODE_HI) begin
         rd_mux = {16'h0, rnode_hi_ff};
      end else if (paddr == `USH_RPORT) begin
         rd_mux = {24'h0, rport_ff};
      end else if (paddr == `USH_STATUS) begin
         rd_mux = {29'h0, en_ff, meas_ff};
      end else if (paddr == `USH_DWELL) begin
         rd_mux = dwell_ff;
      end else if (paddr == `USH_INT_STAT) begin
         rd_mux = {29'h0, ist_ff};
      end else if (paddr == `USH_INT_MASK) begin
         rd_mux = {29'h0, imask_ff};
      end
   end
   // read data and error captured at setup, held through access
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
         err_ff <= 1'b0;
      end else if (setup) begin
         prdata <= pwrite ? 32'h00000000 : rd_mux;
         pslverr <= bad;
         err_ff <= bad;
      end
   end
   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         odd_ff <= 1'b0;
         remote_ff <= 1'b0;
         timeout_ff <= `USH_TIMEOUT_RST;
         dest_ff <= `USH_DEST_RST;
         rnode_lo_ff <= 32'h00000000;
         rnode_hi_ff <= 16'h0000;
         rport_ff <= 8'h00;
         imask_ff <= 3'h0;
      end else if (wr_go) begin
         if (paddr == `USH_CTRL && !busy) begin
            odd_ff <= pwdata[`USH_CTRL_ODD];
            remote_ff <= pwdata[`USH_CTRL_REMOTE];
         end else if (paddr == `USH_TIMEOUT) begin
            timeout_ff <= pwdata[15:0];
         end else if (paddr == `USH_DEST && !busy) begin
            dest_ff <= pwdata[3:0];
         end else if (paddr == `USH_RNODE_LO && !busy) begin
            rnode_lo_ff <= pwdata;
         end else if (paddr == `USH_RNODE_HI && !busy) begin
            rnode_hi_ff <= pwdata[15:0];
         end else if (paddr == `USH_RPORT && !busy) begin
            rport_ff <= pwdata[7:0];
         end else if (paddr == `USH_INT_MASK) begin
            imask_ff <= pwdata[2:0];
         end
      end
   end
   // ----------------------------------------
   // interrupt status, set wins over clear
   // ----------------------------------------
   wire [2:0] ev; // one-cycle events
   assign ev[`USH_IRQ_DONE] = (state_ff == S_WAIT) & rec_ready & (idx_ff == last_w);
   assign ev[`USH_IRQ_TMO] = stop & en_ff & tmo_hit;
   assign ev[`USH_IRQ_SAT] = stop & dwell_max;
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_ist
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ist_ff[gi] <= 1'b0;
            end else if (ev[gi]) begin
               ist_ff[gi] <= 1'b1;
            end else if (wr_go && paddr == `USH_INT_STAT && pwdata[gi]) begin
               ist_ff[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   // ----------------------------------------
   // timeout timer, restarted on rewrite
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_ff <= 32'h00000000;
         sec_ff <= 16'h0000;
      end else if (state_ff != S_RUN || (wr_go && paddr == `USH_TIMEOUT)) begin
         tick_ff <= 32'h00000000;
         sec_ff <= 16'h0000;
      end else if (tick_ff == SEC_TICKS - 1) begin
         tick_ff <= 32'h00000000;
         sec_ff <= sec_ff + 16'h0001;
      end else begin
         tick_ff <= tick_ff + 32'h00000001;
      end
   end
   // ----------------------------------------
   // record word for the current index
   // ----------------------------------------
   reg [31:0] word;
   always @* begin
      word = mem_rd;
      if (idx_ff < `USH_W_NODE_HI) begin
         word = (idx_ff == `USH_W_NODE_HI - 9'h001) ? {id_word[31:8], 8'h00} : id_word;
      end else if (idx_ff == `USH_W_NODE_HI) begin
         word = remote_ff ? {rnode_hi_ff, rnode_lo_ff[31:16]} : 32'h00000000;
      end else if (idx_ff == `USH_W_NODE_LO) begin
         word = {remote_ff ? rnode_lo_ff[15:0] : 16'h0000, remote_ff ? rport_ff : 8'h00, 7'h00, odd_ff};
      end else if (idx_ff == `USH_W_DLEN) begin
         word = 32'h00000001;
      end else if (idx_ff == `USH_W_DWELL) begin
         word = dwell_ff;
      end else if (idx_ff == `USH_W_HLEN) begin
         word = odd_ff ? 32'h000000ff : 32'h00000100;
      end
   end
   // ----------------------------------------
   // tally memory port steering
   // ----------------------------------------
   always @* begin
      mem_ra = hit_bin;
      mem_we = 1'b0;
      mem_wa = bin_ff;
      mem_wd = mem_rd + 32'h00000001;
      if (state_ff == S_CLEAR) begin
         mem_we = 1'b1;
         mem_wa = idx_ff[7:0];
         mem_wd = 32'h00000000;
      end else if (state_ff == S_RUN) begin
         mem_ra = bin_of(smp_data);
         mem_we = upd_ff & ~skip_ff;
      end
   end
   ush_mem #(.W(32), .A(8)) u_mem (
      .clk(pclk),
      .wr_en(mem_we),
      .wr_addr(mem_wa),
      .wr_data(mem_wd),
      .rd_addr(mem_ra),
      .rd_data(mem_rd)
   );
   // ----------------------------------------
   // engine state machine
   // ----------------------------------------
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= S_IDLE;
         en_ff <= 1'b0;
         meas_ff <= `USH_MS_OTHER;
         dwell_ff <= 32'h00000000;
         upd_ff <= 1'b0;
         bin_ff <= 8'h00;
         skip_ff <= 1'b0;
         idx_ff <= 9'h000;
         rec_valid <= 1'b0;
         rec_data <= 32'h00000000;
         rec_last <= 1'b0;
         rec_dest <= 4'h0;
         rec_local <= 1'b0;
      end else begin
         if (wr_go && paddr == `USH_CTRL) begin
            en_ff <= pwdata[`USH_CTRL_EN];
         end else if (stop) begin
            en_ff <= 1'b0;
         end
         upd_ff <= take;
         if (take) begin
            bin_ff <= bin_of(smp_data);
            skip_ff <= odd_ff & (smp_data == 8'h80);
            dwell_ff <= dwell_ff + 32'h00000001;
         end
         case (state_ff)
            S_IDLE: begin
               if (wr_go && paddr == `USH_CTRL && pwdata[`USH_CTRL_EN]) begin
                  state_ff <= S_CLEAR;
                  meas_ff <= `USH_MS_BUSY;
                  dwell_ff <= 32'h00000000;
                  idx_ff <= 9'h000;
               end
            end
            S_CLEAR: begin
               idx_ff <= idx_ff + 9'h001;
               if (idx_ff[7:0] == 8'hff) begin
                  state_ff <= S_RUN;
               end
            end
            S_RUN: begin
               if (stop) begin
                  state_ff <= S_FETCH;
                  idx_ff <= 9'h000;
                  rec_dest <= dest_ff;
                  rec_local <= (dest_ff == 4'h0);
               end
            end
            S_FETCH: begin
               state_ff <= S_LOAD; // tally read issued here
            end
            S_LOAD: begin
               rec_data <= word;
               rec_last <= (idx_ff == last_w);
               rec_valid <= 1'b1;
               state_ff <= S_WAIT;
            end
            S_WAIT: begin
               if (rec_ready) begin
                  rec_valid <= 1'b0;
                  rec_last <= 1'b0;
                  idx_ff <= idx_ff + 9'h001;
                  if (idx_ff == last_w) begin
                     state_ff <= S_IDLE;
                     meas_ff <= `USH_MS_READY;
                  end else begin
                     state_ff <= S_FETCH;
                  end
               end
            end
            default: begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end
endmodule // ush_hist

// File: verilog/ush_defines.vh
// register map, field positions, reset values and timing constants of the histogram engine
`ifndef USH_DEFINES_VH
`define USH_DEFINES_VH
// register byte offsets
`define USH_CTRL 8'h00
`define USH_TIMEOUT 8'h04
`define USH_DEST 8'h08
`define USH_RNODE_LO 8'h0c
`define USH_RNODE_HI 8'h10
`define USH_RPORT 8'h14
`define USH_STATUS 8'h18
`define USH_DWELL 8'h1c
`define USH_INT_STAT 8'h20
`define USH_INT_MASK 8'h24
// control fields
`define USH_CTRL_EN 0
`define USH_CTRL_ODD 1
`define USH_CTRL_REMOTE 2
// reset values
`define USH_TIMEOUT_RST 16'h0708
`define USH_DEST_RST 4'h0
// measurement state codes
`define USH_MS_OTHER 2'h0
`define USH_MS_BUSY 2'h1
`define USH_MS_READY 2'h2
// interrupt bits
`define USH_IRQ_DONE 0
`define USH_IRQ_TMO 1
`define USH_IRQ_SAT 2
// record layout, in 32-bit word indices
`define USH_W_NODE_HI 9'h040
`define USH_W_NODE_LO 9'h041
`define USH_W_DLEN 9'h042
`define USH_W_DWELL 9'h043
`define USH_W_HLEN 9'h044
`define USH_W_HIT0 9'h045
`define USH_W_LAST_EVEN 9'h144
`define USH_W_LAST_ODD 9'h143
// one second in clock cycles at 100 MHz
`define USH_CLK_HZ 100000000
`define USH_SEC_TICKS (`USH_CLK_HZ * 1)
`endif

// File: verilog/ush_mem.v
// single-port-write, registered-read memory that holds the per-bin occurrence tallies
`timescale 1ns/100ps
module ush_mem #(
   parameter W = 32, // word width
   parameter A = 8 // address width
) (
   input wire clk,
   input wire wr_en,
   input wire [A-1:0] wr_addr,
   input wire [W-1:0] wr_data,
   input wire [A-1:0] rd_addr,
   output reg [W-1:0] rd_data
);
   reg [W-1:0] mem [0:(1<<A)-1]; // tally store, cleared by the engine itself

   // ----------------------------------------
   // write and registered read
   // ----------------------------------------
   always @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr]; // old data on same-address collision
   end
endmodule // ush_mem

// File: sim/ush_hist_assertions.sv
// concurrent checks on the record stream and bus answers of the histogram engine
`timescale 1ns/100ps
module ush_hist_chk #(
   parameter SEC_TICKS = 20 // cycles per timeout second
) (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire pslverr,
   input wire smp_valid,
   input wire smp_ready,
   input wire [15:0] profile_map,
   input wire rec_valid,
   input wire [31:0] rec_data,
   input wire rec_last,
   input wire rec_ready,
   input wire [3:0] rec_dest,
   input wire rec_local
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // word position tracker
   // ----------------------------------------
   wire acc = rec_valid & rec_ready; // word handed over
   reg [8:0] wcnt_ff; // index of word on the stream
   reg sym_ff; // odd flag seen in header
   // counts words, grabs the symmetry byte
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wcnt_ff <= 9'h000;
         sym_ff <= 1'b0;
      end else if (acc) begin
         wcnt_ff <= rec_last ? 9'h000 : wcnt_ff + 9'h001;
         if (wcnt_ff == 9'h041) sym_ff <= rec_data[0];
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_id_null: assert property (rec_valid && wcnt_ff == 9'h03f |-> rec_data[7:0] == 8'h00)
      else $error("id string not null terminated");
   a_dwell_len: assert property (rec_valid && wcnt_ff == 9'h042 |-> rec_data == 32'h1)
      else $error("dwell length not one");
   a_hit_len: assert property (rec_valid && wcnt_ff == 9'h044 |-> rec_data == (sym_ff ? 32'hff : 32'h100))
      else $error("hit length wrong");
   a_last_pos: assert property (rec_valid && rec_last |-> wcnt_ff == (sym_ff ? 9'h143 : 9'h144))
      else $error("record ends at wrong word");
   a_rec_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_last))
      else $error("record word dropped while stalled");
   a_rec_gap: assert property (acc && rec_last |=> !rec_valid [*2])
      else $error("stream continues after last word");
   a_smp_gap: assert property (smp_valid && smp_ready |=> !smp_ready)
      else $error("sample taken back to back");
   a_no_smp_rec: assert property (rec_valid |-> !smp_ready)
      else $error("collecting while record is out");
   a_dest_local: assert property (rec_valid |-> rec_local == (rec_dest == 4'h0))
      else $error("local flag disagrees with selector");
   a_dest_err: assert property (psel && penable && pwrite && paddr == 8'h08
      && pwdata[3:0] != 4'h0 && !profile_map[pwdata[3:0]] |-> pslverr)
      else $error("missing profile accepted");
   c_odd_rec: cover property (acc && rec_last && sym_ff);
   c_even_rec: cover property (acc && rec_last && !sym_ff);
   c_bus_err: cover property (psel && penable && pslverr);
endmodule // ush_hist_chk
bind ush_hist ush_hist_chk #(.SEC_TICKS(SEC_TICKS)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
   .smp_valid(smp_valid), .smp_ready(smp_ready), .profile_map(profile_map), .rec_valid(rec_valid),
   .rec_data(rec_data), .rec_last(rec_last), .rec_ready(rec_ready), .rec_dest(rec_dest), .rec_local(rec_local));

// File: sim/ush_rec_sink.sv
// result collector on the record stream, also serves the platform id string
`timescale 1ns/100ps
module ush_rec_sink (
   input wire pclk,
   input wire presetn,
   input wire [5:0] id_index,
   output wire [31:0] id_word,
   input wire rec_valid,
   input wire [31:0] rec_data,
   input wire rec_last,
   input wire [3:0] rec_dest,
   input wire rec_local,
   output wire rec_ready
);
   reg [31:0] mem [0:511]; // collected words
   reg [8:0] cnt_ff; // words of current record
   reg [9:0] len_ff; // length of last record
   reg [3:0] dest_ff; // selector seen with last word
   reg loc_ff; // local flag seen with last word
   reg [1:0] pace_ff; // stall pattern
   // id text, no null of its own: the engine must force it
   assign id_word = {8'h61, 2'h0, id_index, 8'h2e, 8'h62};
   // ready two cycles of four, so both prompt and stalled beats occur
   assign rec_ready = ~pace_ff[1];
   // stores each accepted word, notes length and destination
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff <= 9'h000;
         len_ff <= 10'h000;
         dest_ff <= 4'h0;
         loc_ff <= 1'b0;
         pace_ff <= 2'h0;
      end else begin
         pace_ff <= pace_ff + 2'h1;
         if (rec_valid && rec_ready) begin
            mem[cnt_ff] <= rec_data;
            cnt_ff <= rec_last ? 9'h000 : cnt_ff + 9'h001;
            if (rec_last) begin
               len_ff <= {1'b0, cnt_ff} + 10'h001;
               dest_ff <= rec_dest;
               loc_ff <= rec_local;
            end
         end
      end
   end
endmodule // ush_rec_sink

// File: sim/ush_hist_tb.sv
// self-checking bench: apb tasks, sample feed, record contents
`timescale 1ns/100ps
`include "ush_defines.vh"
`define UCHK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin err_count = err_count + 1; \
   $display("[ERR] %0t %h %h", $time, (a), (b)); end end
module ush_hist_tb;
   reg pclk, presetn, psel, penable, pwrite, smp_valid, er;
   reg [7:0] paddr, smp_data;
   reg [31:0] pwdata, rd;
   reg [15:0] profile_map;
   wire [31:0] prdata, rec_data, id_word;
   wire pready, pslverr, smp_ready, rec_valid, rec_last, rec_ready, rec_local, irq;
   wire [5:0] id_index;
   wire [3:0] rec_dest;
   integer err_count, tests_run, i;
   reg [31:0] hexp [0:255]; // expected hits per bin
   reg [7:0] ev_s [0:4] = '{8'h00, 8'h80, 8'h7f, 8'hff, 8'hff}; // even samples
   reg [7:0] ev_b [0:4] = '{8'h80, 8'h00, 8'hff, 8'h7f, 8'h7f}; // their bins
   reg [7:0] od_s [0:3] = '{8'h80, 8'h81, 8'h00, 8'h7f}; // odd samples
   reg [7:0] od_b [0:3] = '{8'h00, 8'h01, 8'h80, 8'hff}; // bins, 0 = dropped
   // ----------------------------------------
   // design and far side
   // ----------------------------------------
   ush_hist #(.SEC_TICKS(400)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .smp_valid(smp_valid), .smp_data(smp_data), .smp_ready(smp_ready), .profile_map(profile_map),
      .id_index(id_index), .id_word(id_word), .rec_valid(rec_valid), .rec_data(rec_data),
      .rec_last(rec_last), .rec_ready(rec_ready), .rec_dest(rec_dest), .rec_local(rec_local), .irq(irq));
   ush_rec_sink u_part (.pclk(pclk), .presetn(presetn), .id_index(id_index), .id_word(id_word),
      .rec_valid(rec_valid), .rec_data(rec_data), .rec_last(rec_last), .rec_dest(rec_dest),
      .rec_local(rec_local), .rec_ready(rec_ready));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task final_report;
      begin
         if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // one apb transfer; answer taken at the closing edge, settled at the next falling edge
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      reg ok;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         ok = 1'b0;
         for (n = 0; n < 50 && !ok; n = n + 1) begin
            @(posedge pclk);
            ok = (pready === 1'b1);
            rd = prdata;
            er = pslverr;
         end
         if (!ok) begin
            err_count = err_count + 1;
            final_report;
         end
         psel <= 1'b0;
         penable <= 1'b0;
         @(negedge pclk);
      end
   endtask
   // one sample, held until taken
   task smp(input [7:0] s);
      integer n;
      reg ok;
      begin
         @(posedge pclk);
         smp_valid <= 1'b1;
         smp_data <= s;
         ok = 1'b0;
         for (n = 0; n < 600 && !ok; n = n + 1) begin
            @(posedge pclk);
            ok = (smp_ready === 1'b1);
         end
         if (!ok) begin
            err_count = err_count + 1;
            final_report;
         end
         smp_valid <= 1'b0;
         smp_data <= ~s;
      end
   endtask
   // polls status until sample ready
   task wait_ready;
      integer n;
      begin
         rd = 32'h0;
         for (n = 0; n < 3000 && rd[1:0] !== 2'h2; n = n + 1) apb(1'b0, `USH_STATUS, 32'h0);
         if (rd[1:0] !== 2'h2) begin
            err_count = err_count + 1;
            final_report;
         end
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, smp_valid, paddr, smp_data, pwdata} = 0;
      profile_map = 16'h0008;
      err_count = 0;
      tests_run = 0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `USH_TIMEOUT, 32'h0); `UCHK(rd, 32'h708)
      apb(1'b0, `USH_DEST, 32'h0); `UCHK(rd, 32'h0)
      apb(1'b0, 8'h28, 32'h0); `UCHK(er, 1'b1)
      apb(1'b1, `USH_DEST, 32'h5); `UCHK(er, 1'b1)
      // even capture, kept locally, stopped by software
      apb(1'b1, `USH_TIMEOUT, 32'h0);
      apb(1'b1, `USH_INT_MASK, 32'h1);
      apb(1'b1, `USH_CTRL, 32'h1);
      apb(1'b0, `USH_STATUS, 32'h0); `UCHK(rd[2:0], 3'h5)
      for (i = 0; i < 256; i = i + 1) hexp[i] = 32'h0;
      for (i = 0; i < 5; i = i + 1) hexp[ev_b[i]] = hexp[ev_b[i]] + 32'h1;
      for (i = 0; i < 5; i = i + 1) smp(ev_s[i]);
      apb(1'b1, `USH_CTRL, 32'h0);
      wait_ready;
      `UCHK(u_part.len_ff, 10'h145)
      `UCHK(u_part.mem[0], 32'h61002e62)
      `UCHK(u_part.mem[63], 32'h613f2e00)
      `UCHK(u_part.mem[64], 32'h0)
      `UCHK(u_part.mem[65], 32'h0)
      `UCHK(u_part.mem[66], 32'h1)
      `UCHK(u_part.mem[67], 32'h5)
      `UCHK(u_part.mem[68], 32'h100)
      for (i = 0; i < 256; i = i + 1) `UCHK(u_part.mem[69 + i], hexp[i])
      `UCHK(u_part.loc_ff, 1'b1)
      `UCHK(irq, 1'b1)
      apb(1'b1, `USH_INT_STAT, 32'h1);
      `UCHK(irq, 1'b0)
      // odd capture, remote node, sent to profile 3, ended by timeout
      apb(1'b1, `USH_RNODE_LO, 32'h89abcdef);
      apb(1'b1, `USH_RNODE_HI, 32'h4567);
      apb(1'b1, `USH_RPORT, 32'h5a);
      apb(1'b1, `USH_DEST, 32'h3); `UCHK(er, 1'b0)
      apb(1'b1, `USH_INT_MASK, 32'h0);
      apb(1'b1, `USH_TIMEOUT, 32'h1);
      apb(1'b1, `USH_CTRL, 32'h6);
      apb(1'b1, `USH_CTRL, 32'h7);
      apb(1'b1, `USH_CTRL, 32'h7); `UCHK(er, 1'b1)
      for (i = 0; i < 256; i = i + 1) hexp[i] = 32'h0;
      for (i = 1; i < 4; i = i + 1) hexp[od_b[i]] = hexp[od_b[i]] + 32'h1;
      for (i = 0; i < 4; i = i + 1) smp(od_s[i]);
      wait_ready;
      `UCHK(u_part.len_ff, 10'h144)
      `UCHK(u_part.mem[64], 32'h456789ab)
      `UCHK(u_part.mem[65], 32'hcdef5a01)
      `UCHK(u_part.mem[67], 32'h4)
      `UCHK(u_part.mem[68], 32'hff)
      for (i = 1; i < 256; i = i + 1) `UCHK(u_part.mem[68 + i], hexp[i])
      `UCHK({u_part.loc_ff, u_part.dest_ff}, 5'h03)
      apb(1'b0, `USH_CTRL, 32'h0); `UCHK(rd[0], 1'b0)
      apb(1'b0, `USH_INT_STAT, 32'h0); `UCHK(rd[2:0], 3'h3)
      `UCHK(irq, 1'b0)
      apb(1'b1, `USH_INT_MASK, 32'h2);
      `UCHK(irq, 1'b1)
      apb(1'b1, `USH_INT_STAT, 32'h3);
      `UCHK(irq, 1'b0)
      final_report;
   end
endmodule // ush_hist_tb
